/* File: src/terminal_io_pkg.sv */
// Shared constants, port map and field layout of the terminal I/O logic.
// Assumes a 100 MHz system clock; one clock edge stands for one state time.
package terminal_io_pkg;
  // ****************************
  // Timing
  // ****************************
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_DEF = 9600;
  localparam int BIT_CYC_DEF = CLK_HZ / BAUD_DEF;
  localparam int CNT_W = 16;
  // ****************************
  // Widths and depths
  // ****************************
  localparam int CHAR_BITS = 7;
  localparam int WORD_BITS = 8;
  localparam int FIFO_DEPTH_DEF = 64;
  localparam int NUM_FUNCS = 5;
  // ****************************
  // Processor status byte bit positions
  // ****************************
  localparam int ST_MEMR = 7;
  localparam int ST_INP = 6;
  localparam int ST_OUT = 4;
  localparam int ST_WO_N = 1;
  // ****************************
  // I/O channel numbers
  // ****************************
  localparam logic [7:0] PORT_KBD_DATA = 8'h00;
  localparam logic [7:0] PORT_LINE_DATA = 8'h01;
  localparam logic [7:0] PORT_STATUS = 8'h02;
  localparam logic [7:0] PORT_LINE_STAT = 8'h03;
  localparam logic [7:0] PORT_PRINTER = 8'h04;
  localparam logic [7:0] PORT_LINE_CTRL = 8'h05;
  localparam logic [7:0] PORT_DATA_OUT = 8'h06;
  // One-hot function enables
  localparam int FN_KBD = 0;
  localparam int FN_LINE_IN = 1;
  localparam int FN_PRINTER = 2;
  localparam int FN_LINE_CTRL = 3;
  localparam int FN_DATA_OUT = 4;
  // ****************************
  // Line control register bits and reset value
  // ****************************
  localparam int LC_RTS = 0;
  localparam int LC_DTR = 1;
  localparam int LC_BREAK = 2;
  localparam logic [7:0] LC_RESET = 8'h00;
  // ****************************
  // Combined status byte and line status byte
  // ****************************
  localparam int SB_RX_AVAIL = 0;
  localparam int SB_PAR_ERR = 1;
  localparam int SB_FRM_ERR = 2;
  localparam int SB_OVERRUN = 3;
  localparam int SB_KBD_RDY = 4;
  localparam int SB_TX_BUSY = 5;
  localparam int SB_PRN_BUSY = 6;
  localparam int LS_DCD = 0;
  localparam int LS_CTS = 1;
  localparam int LS_DSR = 2;
  localparam int LS_RI = 3;

  // Parity bit that gives the word even or odd total parity
  function automatic logic par7(input logic [CHAR_BITS-1:0] d,
                                input logic odd);
    return (^d) ^ odd;
  endfunction
endpackage

/* File: src/serial_rx.sv */
// Asynchronous receiver: start, 7 data bits, parity, one stop bit.
// Assumes the serial input is already synchronous to clk.
`timescale 1ns/100ps
module serial_rx import terminal_io_pkg::*; #(
  parameter int BIT_CYC = BIT_CYC_DEF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rxd,
  input wire logic parityOdd,
  output logic done,
  output logic [WORD_BITS-1:0] word,
  output logic parErr,
  output logic frmErr
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rxst_t;
  typedef struct packed {
    rxst_t st;
    logic [CNT_W-1:0] cnt;
    logic [2:0] idx;
    logic [WORD_BITS-1:0] shift;
    logic done;
    logic [WORD_BITS-1:0] word;
    logic parErr;
    logic frmErr;
  } rx_t;
  localparam logic [CNT_W-1:0] FULL = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF = CNT_W'(BIT_CYC / 2);
  rx_t r_r, r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    r_nxt.cnt = r_r.cnt + 1'b1;
    case (r_r.st)
      RX_IDLE: begin
        r_nxt.cnt = '0;
        if (!rxd) r_nxt.st = RX_START;
      end
      RX_START: begin
        // Mid-bit recheck rejects glitches as start bits
        if (r_r.cnt == HALF) begin
          r_nxt.cnt = '0;
          r_nxt.idx = '0;
          r_nxt.st = rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (r_r.cnt == FULL) begin
          r_nxt.cnt = '0;
          r_nxt.shift = {rxd, r_r.shift[WORD_BITS-1:1]}; // (R7)
          r_nxt.idx = r_r.idx + 1'b1;
          if (r_r.idx == 3'd7) r_nxt.st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (r_r.cnt == FULL) begin
          r_nxt.st = RX_IDLE;
          r_nxt.done = 1'b1; // (R7)
          r_nxt.word = r_r.shift;
          r_nxt.parErr = r_r.shift[WORD_BITS-1] !=
            par7(r_r.shift[CHAR_BITS-1:0], parityOdd); // (R9) (R10)
          r_nxt.frmErr = !rxd; // (R9)
        end
      end
      default: r_nxt.st = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) r_r <= '0;
    else r_r <= r_nxt;
  end

  assign done = r_r.done;
  assign word = r_r.word;
  assign parErr = r_r.parErr;
  assign frmErr = r_r.frmErr;
endmodule

/* File: src/serial_tx.sv */
// Asynchronous transmitter: start, 7 data bits, parity, one stop bit.
// Assumes start is only pulsed while busy is low.
`timescale 1ns/100ps
module serial_tx import terminal_io_pkg::*; #(
  parameter int BIT_CYC = BIT_CYC_DEF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [CHAR_BITS-1:0] data,
  input wire logic parityOdd,
  output logic txd,
  output logic busy
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [3:0] idx;
    logic [9:0] shift;
    logic txd;
    logic busy;
  } tx_t;
  localparam logic [CNT_W-1:0] FULL = CNT_W'(BIT_CYC - 1);
  tx_t t_r, t_nxt;

  always_comb begin
    t_nxt = t_r;
    t_nxt.cnt = t_r.cnt + 1'b1;
    if (!t_r.busy) begin
      t_nxt.cnt = '0;
      if (start) begin
        t_nxt.shift = {1'b1, par7(data, parityOdd), data, 1'b0}; // (R8)
        t_nxt.txd = 1'b0;
        t_nxt.idx = '0;
        t_nxt.busy = 1'b1;
      end
    end else if (t_r.cnt == FULL) begin
      t_nxt.cnt = '0;
      if (t_r.idx == 4'd9) begin
        t_nxt.busy = 1'b0;
        t_nxt.txd = 1'b1;
      end else begin
        t_nxt.shift = {1'b1, t_r.shift[9:1]};
        t_nxt.txd = t_r.shift[1]; // (R8)
        t_nxt.idx = t_r.idx + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      t_r <= '0;
      t_r.txd <= 1'b1;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign txd = t_r.txd;
  assign busy = t_r.busy;
endmodule

/* File: src/terminal_io_serial_interface.sv */
// Processor card I/O logic: cycle tracking, I/O and memory decode,
// bus drivers, input multiplexer, receive FIFO, serial link, indicators.
// Assumes the processor is outside, one clk edge per state time, and all
// inputs synchronous to clk.
//
// Summary of operation
// (R1) Ready still low at end of second state time sends cycle into wait.
// (R2) Wait indication stays high until the responder gives ready.
// (R3) Input multiplexer picks one of four sources by active input function.
// (R4) Input data driven onto shared data bus only during own input function.
// (R5) Keyboard character arrival sets a ready flag until read.
// (R6) Modem data to receiver, status to multiplexer, carrier gates FIFO.
// (R7) Receiver assembles 7-bit characters and loads each into the FIFO; code loads one only while dcd is high and the FIFO is not full.
// (R8) Transmitter sends 7-bit bus codes as serial frames to the modem.
// (R9) Parity error flagged per character; framing error when stop is space.
// (R10) Parity mode input chooses even or odd parity checking.
// (R11) FIFO holds 64 words of 7 data bits plus parity.
// (R12) Each line data input pops exactly one word, oldest first; code pops nothing when the FIFO is empty.
// (R13) Decode recognises I/O cycles and pulses input or output strobe.
// (R14) Five I/O functions decoded, each with its own enable.
// (R15) Memory read or write cycles indicated to the shared bus.
// (R16) Bus data passed to processor on input, driven out on output.
// (R17) Address driven onto shared bus while processor addresses a card.
// (R18) Line control output loads the whole data byte into control register.
// (R19) RTS and DTR lamps follow their line control register bits.
// (R20) Lamps show live transmit, receive, carrier and clear-to-send.
// (R21) Power or panel reset clears the card and goes out to the bus.
// (R22) Status byte sampled while sync is active to classify the cycle.
// (R23) Data bus direction input steers data drivers and receivers.
// (R24) Line control bit positions fixed as named constants.
// (R25) Empty FIFO read returns zero; status shows data available.
`timescale 1ns/100ps
module terminal_io_serial_interface import terminal_io_pkg::*; #(
  parameter int BIT_CYC = BIT_CYC_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic panelReset,
  input wire logic [15:0] procAddr,
  input wire logic [7:0] procDataI,
  output logic [7:0] procDataO,
  output logic procDataOe,
  input wire logic sync,
  input wire logic busInboundFlag,
  output logic procReady,
  output logic waitInd,
  output logic procReset,
  input wire logic [7:0] busDataI,
  output logic [7:0] busDataO,
  output logic busDataOe,
  output logic [15:0] busAddrO,
  output logic busAddrOe,
  output logic busMemRead,
  output logic busMemWrite,
  input wire logic busReady,
  output logic busResetOut,
  output logic inStrobe,
  output logic outStrobe,
  output logic [NUM_FUNCS-1:0] funcEn,
  input wire logic kbdStrobe,
  input wire logic [CHAR_BITS-1:0] kbdCode,
  input wire logic prnBusy,
  output logic [7:0] prnData,
  output logic prnStrobe,
  output logic [7:0] genData,
  output logic genStrobe,
  input wire logic parityOdd,
  input wire logic rxd,
  input wire logic dcd,
  input wire logic cts,
  input wire logic dsr,
  input wire logic ring,
  output logic txd,
  output logic rts,
  output logic dtr,
  output logic ledRts,
  output logic ledDtr,
  output logic ledTxd,
  output logic ledRxd,
  output logic ledDcd,
  output logic ledCts
);
  localparam int PW = $clog2(FIFO_DEPTH);

  typedef enum logic [2:0] {C_IDLE, C_T1, C_T2, C_TW, C_T3} cyc_t;
  typedef struct packed {
    cyc_t cyc;
    logic [7:0] status;
    logic [7:0] port;
    logic [NUM_FUNCS-1:0] fn;
    logic ownIn;
    logic [7:0] procDataO;
    logic procDataOe;
    logic procReady;
    logic waitInd;
    logic procReset;
    logic [7:0] busDataO;
    logic busDataOe;
    logic [15:0] busAddrO;
    logic busAddrOe;
    logic busMemRead;
    logic busMemWrite;
    logic busResetOut;
    logic inStrobe;
    logic outStrobe;
    logic [NUM_FUNCS-1:0] funcEn;
    logic [CHAR_BITS-1:0] kbdChar;
    logic kbdReady;
    logic parErr;
    logic frmErr;
    logic overrun;
    logic [7:0] lineCtrl;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    logic [7:0] prnData;
    logic prnStrobe;
    logic [7:0] genData;
    logic genStrobe;
    logic txStart;
    logic [CHAR_BITS-1:0] txData;
    logic txd;
    logic ledRts;
    logic ledDtr;
    logic ledTxd;
    logic ledRxd;
    logic ledDcd;
    logic ledCts;
  } card_t;

  card_t s_r, s_nxt;
  logic [WORD_BITS-1:0] fifoMem [FIFO_DEPTH];
  logic cardRst;
  logic rxDone;
  logic [WORD_BITS-1:0] rxWord;
  logic rxParErr;
  logic rxFrmErr;
  logic txLine;
  logic txBusy;
  logic push;
  logic pop;

  // ****************************
  // Function decode and input selection
  // ****************************
  function automatic logic [NUM_FUNCS-1:0] decodeFn(input logic inp,
                                                    input logic outp,
                                                    input logic [7:0] p);
    logic [NUM_FUNCS-1:0] f;
    f = '0;
    f[FN_KBD] = inp && (p == PORT_KBD_DATA);
    f[FN_LINE_IN] = inp && (p == PORT_LINE_DATA);
    f[FN_PRINTER] = outp && (p == PORT_PRINTER);
    f[FN_LINE_CTRL] = outp && (p == PORT_LINE_CTRL);
    f[FN_DATA_OUT] = outp && (p == PORT_DATA_OUT);
    return f; // (R14)
  endfunction

  function automatic logic ownInput(input logic [7:0] p);
    return (p == PORT_KBD_DATA) || (p == PORT_LINE_DATA) ||
           (p == PORT_STATUS) || (p == PORT_LINE_STAT);
  endfunction

  // ****************************
  // Serial receiver and transmitter
  // ****************************
  assign cardRst = !reset_n || panelReset; // (R21)

  serial_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk(clk),
    .reset_n(!cardRst),
    .rxd(rxd), // (R6)
    .parityOdd(parityOdd),
    .done(rxDone),
    .word(rxWord),
    .parErr(rxParErr),
    .frmErr(rxFrmErr)
  );

  serial_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk(clk),
    .reset_n(!cardRst),
    .start(s_r.txStart),
    .data(s_r.txData),
    .parityOdd(parityOdd),
    .txd(txLine),
    .busy(txBusy)
  );

  // ****************************
  // Cycle tracking, decode and side effects
  // ****************************
  always_comb begin
    logic rdy;
    logic [7:0] inData;
    logic inp;
    logic outp;
    logic memW;
    rdy = 1'b0;
    inData = 8'h00;
    inp = s_r.status[ST_INP];
    outp = s_r.status[ST_OUT];
    memW = !s_r.status[ST_WO_N] && !outp;
    s_nxt = s_r;
    s_nxt.procReset = 1'b0;
    s_nxt.busResetOut = 1'b0;
    s_nxt.inStrobe = 1'b0;
    s_nxt.outStrobe = 1'b0;
    s_nxt.prnStrobe = 1'b0;
    s_nxt.genStrobe = 1'b0;
    s_nxt.txStart = 1'b0;
    push = 1'b0;
    pop = 1'b0;

    // Own input and output functions answer at once; others wait for the bus
    rdy = s_r.ownIn || (|s_r.fn) || busReady;

    case (s_r.port)
      PORT_LINE_DATA:
        // Empty FIFO reads as zero
        inData = (s_r.count != '0) ? fifoMem[s_r.rdPtr] : 8'h00; // (R25)
      PORT_STATUS: begin
        inData[SB_RX_AVAIL] = s_r.count != '0; // (R25)
        inData[SB_PAR_ERR] = s_r.parErr;
        inData[SB_FRM_ERR] = s_r.frmErr;
        inData[SB_OVERRUN] = s_r.overrun;
        inData[SB_KBD_RDY] = s_r.kbdReady;
        inData[SB_TX_BUSY] = txBusy;
        inData[SB_PRN_BUSY] = prnBusy;
      end
      PORT_KBD_DATA: inData = {1'b0, s_r.kbdChar};
      PORT_LINE_STAT: begin
        inData[LS_DCD] = dcd; // (R6)
        inData[LS_CTS] = cts;
        inData[LS_DSR] = dsr;
        inData[LS_RI] = ring;
      end
      default: inData = 8'h00;
    endcase // (R3)

    case (s_r.cyc)
      C_IDLE: begin
        s_nxt.procReady = 1'b0;
      end
      C_T1: begin
        s_nxt.cyc = C_T2;
        s_nxt.port = procAddr[7:0];
        s_nxt.fn = decodeFn(inp, outp, procAddr[7:0]); // (R13)
        s_nxt.ownIn = inp && ownInput(procAddr[7:0]);
        s_nxt.busAddrO = procAddr;
        s_nxt.busAddrOe = 1'b1; // (R17)
        s_nxt.busMemRead = s_r.status[ST_MEMR]; // (R15)
        s_nxt.busMemWrite = memW; // (R15)
      end
      C_T2, C_TW: begin
        s_nxt.procReady = rdy;
        s_nxt.waitInd = !rdy; // (R2)
        s_nxt.cyc = rdy ? C_T3 : C_TW; // (R1)
        s_nxt.funcEn = s_r.fn;
        if (busInboundFlag) begin
          // Input: receivers feed the processor
          s_nxt.procDataO = s_r.ownIn ? inData : busDataI; // (R16) (R23)
          s_nxt.procDataOe = 1'b1;
          s_nxt.busDataO = inData;
          s_nxt.busDataOe = s_r.ownIn; // (R4)
          s_nxt.inStrobe = inp && rdy; // (R13)
        end else begin
          // Output: drivers carry the processor word to the bus
          s_nxt.procDataOe = 1'b0;
          s_nxt.busDataO = procDataI;
          s_nxt.busDataOe = outp || memW; // (R16) (R23)
          s_nxt.outStrobe = outp && rdy; // (R13)
        end
      end
      C_T3: begin
        s_nxt.cyc = C_IDLE;
        s_nxt.waitInd = 1'b0;
        s_nxt.procReady = 1'b0;
        s_nxt.procDataOe = 1'b0;
        s_nxt.busDataOe = 1'b0;
        s_nxt.busAddrOe = 1'b0;
        s_nxt.busMemRead = 1'b0;
        s_nxt.busMemWrite = 1'b0;
        s_nxt.funcEn = '0;
        if (s_r.fn[FN_KBD]) s_nxt.kbdReady = 1'b0;
        if (s_r.fn[FN_LINE_IN] && s_r.count != '0) pop = 1'b1; // (R12)
        if (s_r.ownIn && s_r.port == PORT_STATUS) begin
          s_nxt.parErr = 1'b0;
          s_nxt.frmErr = 1'b0;
          s_nxt.overrun = 1'b0;
        end
        if (s_r.fn[FN_LINE_CTRL]) s_nxt.lineCtrl = s_r.busDataO; // (R18)
        if (s_r.fn[FN_PRINTER]) begin
          s_nxt.prnData = s_r.busDataO;
          s_nxt.prnStrobe = 1'b1;
        end
        if (s_r.fn[FN_DATA_OUT]) begin
          s_nxt.genData = s_r.busDataO;
          s_nxt.genStrobe = 1'b1;
          // Dropped while a frame is on the line; software polls busy
          if (!txBusy) begin
            s_nxt.txData = s_r.busDataO[CHAR_BITS-1:0]; // (R8)
            s_nxt.txStart = 1'b1;
          end
        end
      end
      default: s_nxt.cyc = C_IDLE;
    endcase

    // Sync starts a new machine cycle whatever state we are in
    if (sync) begin
      s_nxt.cyc = C_T1;
      s_nxt.status = procDataI; // (R22)
      s_nxt.busAddrOe = 1'b0;
      s_nxt.busDataOe = 1'b0;
      s_nxt.procDataOe = 1'b0;
      s_nxt.waitInd = 1'b0;
    end

    // Events set after the clears so a same-cycle arrival wins over a clear
    if (kbdStrobe) begin
      s_nxt.kbdChar = kbdCode;
      s_nxt.kbdReady = 1'b1; // (R5)
    end
    if (rxDone) begin
      s_nxt.parErr = s_nxt.parErr || rxParErr; // (R9)
      s_nxt.frmErr = s_nxt.frmErr || rxFrmErr; // (R9)
      if (dcd) begin
        // Carrier gates loading; a full FIFO drops the new word
        if (s_r.count != (PW+1)'(FIFO_DEPTH)) push = 1'b1; // (R6) (R11)
        else s_nxt.overrun = 1'b1;
      end
    end
    if (push) s_nxt.wrPtr = s_r.wrPtr + 1'b1;
    if (pop) s_nxt.rdPtr = s_r.rdPtr + 1'b1;
    if (push && !pop) s_nxt.count = s_r.count + 1'b1;
    if (pop && !push) s_nxt.count = s_r.count - 1'b1;

    // Modem controls and panel lamps
    s_nxt.txd = txLine && !s_r.lineCtrl[LC_BREAK]; // (R24)
    s_nxt.ledRts = s_r.lineCtrl[LC_RTS]; // (R19) (R24)
    s_nxt.ledDtr = s_r.lineCtrl[LC_DTR]; // (R19) (R24)
    s_nxt.ledTxd = s_r.txd; // (R20)
    s_nxt.ledRxd = rxd; // (R20)
    s_nxt.ledDcd = dcd; // (R20)
    s_nxt.ledCts = cts; // (R20)
  end

  // ****************************
  // State and FIFO storage
  // ****************************
  always_ff @(posedge clk) begin
    if (cardRst) begin
      s_r <= '0;
      s_r.lineCtrl <= LC_RESET;
      s_r.txd <= 1'b1;
      s_r.ledTxd <= 1'b1;
      s_r.procReset <= 1'b1; // (R21)
      s_r.busResetOut <= 1'b1; // (R21)
    end else begin
      s_r <= s_nxt;
    end
  end

  // Storage has no reset; the pointers and count define contents
  always_ff @(posedge clk) begin
    if (push) fifoMem[s_r.wrPtr] <= rxWord; // (R7) (R11)
  end

  // ****************************
  // Outputs
  // ****************************
  assign procDataO = s_r.procDataO;
  assign procDataOe = s_r.procDataOe;
  assign procReady = s_r.procReady;
  assign waitInd = s_r.waitInd;
  assign procReset = s_r.procReset;
  assign busDataO = s_r.busDataO;
  assign busDataOe = s_r.busDataOe;
  assign busAddrO = s_r.busAddrO;
  assign busAddrOe = s_r.busAddrOe;
  assign busMemRead = s_r.busMemRead;
  assign busMemWrite = s_r.busMemWrite;
  assign busResetOut = s_r.busResetOut;
  assign inStrobe = s_r.inStrobe;
  assign outStrobe = s_r.outStrobe;
  assign funcEn = s_r.funcEn;
  assign prnData = s_r.prnData;
  assign prnStrobe = s_r.prnStrobe;
  assign genData = s_r.genData;
  assign genStrobe = s_r.genStrobe;
  assign txd = s_r.txd;
  assign rts = s_r.lineCtrl[LC_RTS];
  assign dtr = s_r.lineCtrl[LC_DTR];
  assign ledRts = s_r.ledRts;
  assign ledDtr = s_r.ledDtr;
  assign ledTxd = s_r.ledTxd;
  assign ledRxd = s_r.ledRxd;
  assign ledDcd = s_r.ledDcd;
  assign ledCts = s_r.ledCts;
endmodule

/* File: tb/terminal_io_asserts.sv */
// Port-level checks for the terminal I/O card top module.
// Assumes one clock domain; bound into every instance below.
`timescale 1ns/100ps
module terminal_io_asserts import terminal_io_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic panelReset,
  input wire logic sync,
  input wire logic [7:0] procDataI,
  input wire logic procReady,
  input wire logic waitInd,
  input wire logic procReset,
  input wire logic busResetOut,
  input wire logic procDataOe,
  input wire logic busAddrOe,
  input wire logic busMemRead,
  input wire logic inStrobe,
  input wire logic outStrobe,
  input wire logic [NUM_FUNCS-1:0] funcEn,
  input wire logic dcd,
  input wire logic cts,
  input wire logic rts,
  input wire logic ledRts,
  input wire logic ledDcd,
  input wire logic ledCts
);
  // ****************************
  // Properties
  // ****************************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Lamp checks skip the edge after any reset
  logic live;
  assign live = reset_n && !panelReset;
  a_reset_out: assert property (panelReset |=> procReset && busResetOut)
    else $error("reset not driven out");
  a_mem_read: assert property ($rose(busMemRead) |-> $past(sync, 2) &&
    $past(procDataI[ST_MEMR], 2)) else $error("memory read without status");
  a_in_strobe: assert property ($rose(inStrobe) && !$past(waitInd) |->
    $past(sync, 3) && $past(procDataI[ST_INP], 3))
    else $error("input strobe misplaced");
  a_out_strobe: assert property ($rose(outStrobe) && !$past(waitInd) |->
    $past(sync, 3) && $past(procDataI[ST_OUT], 3))
    else $error("output strobe misplaced");
  a_func_onehot: assert property ($onehot0(funcEn))
    else $error("two functions enabled");
  a_wait_ready: assert property (waitInd |-> !procReady)
    else $error("wait with ready");
  a_oe_span: assert property (procDataOe |-> busAddrOe)
    else $error("data driven without address");
  a_lamp_lines: assert property ($past(live) |-> ledCts == $past(cts) &&
    ledDcd == $past(dcd)) else $error("line lamps stale");
  a_lamp_rts: assert property ($past(live) && $stable(rts) |->
    ledRts == rts) else $error("rts lamp wrong");
  c_wait: cover property ($rose(waitInd));
  c_in: cover property ($rose(inStrobe));
  c_out: cover property ($rose(outStrobe));
endmodule
bind terminal_io_serial_interface terminal_io_asserts chk_u (.clk, .reset_n,
  .panelReset, .sync, .procDataI, .procReady, .waitInd, .procReset,
  .busResetOut, .procDataOe, .busAddrOe, .busMemRead, .inStrobe, .outStrobe,
  .funcEn, .dcd, .cts, .rts, .ledRts, .ledDcd, .ledCts);

/* File: tb/modem_model.sv */
// Modem side of the serial link: sends frames, captures card frames.
// Assumes the card uses the same bit time in clk cycles.
`timescale 1ns/100ps
module modem_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic got,
  output logic [7:0] gotWord
);
  // ****************************
  // Frames
  // ****************************
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    gotWord = 8'h00;
  end
  // Start, 7 data LSB first, parity, stop; line idles at mark
  task automatic send(input logic [6:0] d, input logic p, input logic stp);
    logic [9:0] f;
    f = {stp, p, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd = f[i];
      repeat (BIT_CYC) @(negedge clk);
    end
    rxd = 1'b1;
  endtask
  // A spacing stop bit is never reported, so the pending check fails
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      gotWord[i] = txd;
    end
    repeat (BIT_CYC) @(posedge clk);
    got = txd;
    @(posedge clk);
    got = 1'b0;
  end
endmodule

/* File: tb/tb_terminal_io_serial_interface.sv */
// Self-checking bench for the terminal I/O card logic.
// Assumes the checker is bound and the modem model sits on the link.
`timescale 1ns/100ps
module tb_terminal_io_serial_interface import terminal_io_pkg::*;;
  // ****************************
  // Stimulus and checking
  // ****************************
  logic reset_n, panelReset, sync, busInboundFlag, procReady, waitInd;
  logic procReset, procDataOe, busDataOe, busAddrOe, busMemRead, busMemWrite;
  logic busReady, busResetOut, inStrobe, outStrobe, kbdStrobe, prnBusy;
  logic prnStrobe, genStrobe, parityOdd, rxd, dcd, cts, dsr, ring, txd;
  logic rts, dtr, ledRts, ledDtr, ledTxd, ledRxd, ledDcd, ledCts, got;
  bit clk, sawWait;
  logic [15:0] procAddr, busAddrO, e;
  logic [7:0] procDataI, procDataO, busDataI, busDataO, prnData, genData;
  logic [7:0] gotWord, w[3];
  logic [6:0] kbdCode, d;
  logic [4:0] funcEn;
  logic [15:0] expq[$];
  logic [7:0] txq[$];
  int n_errors = 0;
  int checked = 0;
  terminal_io_serial_interface #(.BIT_CYC(8), .FIFO_DEPTH(64)) dut_u (.clk,
    .reset_n, .panelReset, .procAddr, .procDataI, .procDataO, .procDataOe,
    .sync, .busInboundFlag, .procReady, .waitInd, .procReset, .busDataI,
    .busDataO, .busDataOe, .busAddrO, .busAddrOe, .busMemRead, .busMemWrite,
    .busReady, .busResetOut, .inStrobe, .outStrobe, .funcEn, .kbdStrobe,
    .kbdCode, .prnBusy, .prnData, .prnStrobe, .genData, .genStrobe,
    .parityOdd, .rxd, .dcd, .cts, .dsr, .ring, .txd, .rts, .dtr, .ledRts,
    .ledDtr, .ledTxd, .ledRxd, .ledDcd, .ledCts);
  modem_model #(.BIT_CYC(8)) modem_u (.clk, .txd, .rxd, .got, .gotWord);
  always #5 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] ex, s);
    checked++;
    if (s !== ex) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, s);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One processor I/O cycle: sync, T1, T2, T3
  task automatic io(input logic rd, input logic [7:0] port, wd);
    sync = 1'b1;
    procDataI = rd ? 8'h42 : 8'h10;
    @(negedge clk);
    sync = 1'b0;
    procAddr = {port, port};
    procDataI = wd;
    busInboundFlag = rd;
    repeat (3) @(negedge clk);
    busInboundFlag = 1'b0;
  endtask
  task automatic rdx(input logic [7:0] port, ex, m);
    expq.push_back({m, ex});
    io(1'b1, port, 8'h00);
  endtask
  // Memory read; responder holds ready low for lag cycles
  task automatic memrd(input int lag);
    busDataI = 8'($urandom);
    busReady = (lag == 0);
    expq.push_back({8'hff, busDataI});
    sync = 1'b1;
    procDataI = 8'h82;
    @(negedge clk);
    sync = 1'b0;
    procAddr = 16'h4000;
    busInboundFlag = 1'b1;
    repeat (lag) @(negedge clk);
    busReady = 1'b1;
    for (int i = 0; i < 9 && procReady !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    busInboundFlag = 1'b0;
  endtask
  always @(negedge clk) begin
    if (waitInd === 1'b1) sawWait = 1'b1;
    if (procDataOe === 1'b1 && procReady === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 16'hff00;
      chk("procDataO", e[7:0] & e[15:8], procDataO & e[15:8]);
    end
    if (got === 1'b1) chk("txWord", txq.pop_front(), gotWord);
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    close_out;
  end
  initial begin
    {reset_n, panelReset, sync, busInboundFlag, kbdStrobe, prnBusy} = '0;
    {parityOdd, cts, dsr, ring, sawWait} = '0;
    {dcd, busReady} = 2'b11;
    {procAddr, procDataI, busDataI, kbdCode} = '0;
    void'($urandom(88));
    repeat (5) @(negedge clk);
    chk("procReset", 8'h01, 8'(procReset));
    chk("busResetOut", 8'h01, 8'(busResetOut));
    reset_n = 1'b1;
    rdx(PORT_LINE_DATA, 8'h00, 8'hff);
    rdx(PORT_STATUS, 8'h00, 8'hff);
    for (int m = 0; m < 2; m++) begin
      parityOdd = m[0];
      for (int k = 0; k < 3; k++) begin
        d = 7'($urandom);
        w[k] = {^d ^ m[0], d};
        modem_u.send(d, w[k][7], 1'b1);
      end
      rdx(PORT_STATUS, 8'h01, 8'h0f);
      for (int k = 0; k < 3; k++) rdx(PORT_LINE_DATA, w[k], 8'hff);
    end
    d = 7'($urandom);
    modem_u.send(d, ~(^d ^ parityOdd), 1'b1);
    rdx(PORT_STATUS, 8'h03, 8'h0f);
    rdx(PORT_STATUS, 8'h01, 8'h0f);
    rdx(PORT_LINE_DATA, {~(^d ^ parityOdd), d}, 8'hff);
    dcd = 1'b0;
    modem_u.send(d, ^d ^ parityOdd, 1'b0);
    rdx(PORT_STATUS, 8'h04, 8'h0f);
    dcd = 1'b1;
    kbdCode = 7'($urandom);
    kbdStrobe = 1'b1;
    @(negedge clk);
    kbdStrobe = 1'b0;
    rdx(PORT_STATUS, 8'h10, 8'h10);
    rdx(PORT_KBD_DATA, {1'b0, kbdCode}, 8'hff);
    rdx(PORT_STATUS, 8'h00, 8'h10);
    {ring, dsr, cts, dcd} = 4'($urandom);
    rdx(PORT_LINE_STAT, {4'h0, ring, dsr, cts, dcd}, 8'hff);
    dcd = 1'b1;
    io(1'b0, PORT_LINE_CTRL, 8'h03);
    repeat (3) @(negedge clk);
    chk("rtsDtr", 8'h0f, {4'h0, rts, dtr, ledRts, ledDtr});
    panelReset = 1'b1;
    @(negedge clk);
    panelReset = 1'b0;
    chk("panelReset", 8'h06, 8'({procReset, busResetOut, rts}));
    d = 7'($urandom);
    txq.push_back({^d ^ parityOdd, d});
    io(1'b0, PORT_DATA_OUT, {1'b0, d});
    chk("genData", {1'b0, d}, genData);
    for (int i = 0; i < 300 && txq.size() > 0; i++) @(negedge clk);
    memrd(0);
    chk("noWait", 8'h00, 8'(sawWait));
    memrd(4);
    chk("wait", 8'h01, 8'(sawWait));
    chk("pending", 8'h00, 8'(expq.size() + txq.size()));
    close_out;
  end
endmodule
